// ==== include/asc_pkg.sv ====
// package: register map, field layout, reset values and carriers of the setup bank
package asc_pkg;

    // ----------------------------------------
    // bus geometry
    // ----------------------------------------
    localparam int ASC_ADDR_W = 8;
    localparam int ASC_DATA_W = 32;

    // ----------------------------------------
    // register byte offsets
    // ----------------------------------------
    localparam logic [ASC_ADDR_W-1:0] ASC_OFS_MODE_CTRL = 8'h00;
    localparam logic [ASC_ADDR_W-1:0] ASC_OFS_OUT_REF = 8'h08;
    localparam logic [ASC_ADDR_W-1:0] ASC_OFS_DAC_CHAN = 8'h0C;
    localparam logic [ASC_ADDR_W-1:0] ASC_OFS_SOFT_RST = 8'h10;
    localparam logic [ASC_ADDR_W-1:0] ASC_OFS_STATUS = 8'h14;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int ASC_MODE_SINGLE_BIT = 0;
    localparam int ASC_MODE_COMPAT_BIT = 1;
    localparam int ASC_MODE_TMODE_LSB = 2;
    localparam int ASC_OUT_DAC_RANGE_BIT = 5;
    localparam int ASC_OUT_LAT_LSB = 6;
    localparam int ASC_DAC_CODE_LSB = 0;
    localparam int ASC_DAC_CDSREF_LSB = 4;
    localparam int ASC_DAC_CHAN_LSB = 6;
    localparam int ASC_STAT_LAT_LSB = 0;
    localparam int ASC_STAT_CHAN_LSB = 7;
    localparam int ASC_STAT_CDS_LSB = 9;
    localparam int ASC_STAT_BUSY_BIT = 11;
    localparam int ASC_STAT_SINGLE_BIT = 12;
    localparam int ASC_STAT_COMPAT_BIT = 13;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [7:0] ASC_MODE_CTRL_RST = 8'h04;
    localparam logic [7:0] ASC_OUT_REF_RST = 8'h20;
    localparam logic [7:0] ASC_DAC_CHAN_RST = 8'h1F;
    localparam logic [1:0] ASC_CDSREF_DEFAULT = 2'h1;

    // ----------------------------------------
    // codes
    // ----------------------------------------
    localparam logic [2:0] ASC_TMODE_3 = 3'h3;
    localparam logic [1:0] ASC_CHAN_RED = 2'h0;
    localparam logic [1:0] ASC_CHAN_GREEN = 2'h1;
    localparam logic [1:0] ASC_CHAN_BLUE = 2'h2;
    localparam logic [1:0] ASC_RESP_OKAY = 2'h0;
    localparam logic [1:0] ASC_RESP_SLVERR = 2'h2;

    // ----------------------------------------
    // latency in half master clock periods
    // ----------------------------------------
    localparam logic [6:0] ASC_LAT_NORM_BASE = 7'h0E;
    localparam logic [6:0] ASC_LAT_NORM_STEP = 7'h02;
    localparam logic [6:0] ASC_LAT_COMPAT_BASE = 7'h21;
    localparam logic [6:0] ASC_LAT_COMPAT_STEP = 7'h04;
    localparam logic [6:0] ASC_LAT_MODE3_BASE = 7'h2F;
    localparam logic [6:0] ASC_LAT_MODE3_STEP = 7'h06;

    // ----------------------------------------
    // carriers
    // ----------------------------------------
    typedef struct packed {
        logic awvalid;
        logic [ASC_ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [ASC_DATA_W-1:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [ASC_ADDR_W-1:0] araddr;
        logic rready;
    } asc_axil_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [ASC_DATA_W-1:0] rdata;
        logic [1:0] rresp;
    } asc_axil_rsp_t;

    typedef struct packed {
        logic [3:0] dac_code;
        logic dac_range;
        logic [2:0] chan_power;
        logic [1:0] chan_select;
        logic [1:0] cds_reset_adjust;
        logic [6:0] latency_half;
    } asc_ctrl_t;

    typedef struct packed {
        logic valid;
        logic half_late;
        logic [15:0] data;
    } asc_sample_t;

    typedef enum logic [1:0] {
        ASC_WS_IDLE = 2'b00,
        ASC_WS_HALF = 2'b01,
        ASC_WS_RESP = 2'b11
    } asc_wstate_t;

    typedef enum logic {
        ASC_RS_IDLE = 1'b0,
        ASC_RS_RESP = 1'b1
    } asc_rstate_t;

endpackage

// ==== design/asc_lat_slot.sv ====
// one in-flight sample holder counting down its own latency
module asc_lat_slot
    import asc_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic arst_n,
    input wire logic clear,
    // load side
    input wire logic load,
    input wire logic [5:0] load_count,
    input wire logic load_half,
    input wire logic [15:0] load_data,
    // fire side
    output logic fire,
    output logic busy,
    output logic half_late,
    output logic [15:0] data
);

    typedef struct packed {
        logic busy;
        logic [5:0] count;
        logic half;
        logic [15:0] data;
    } asc_slot_state_t;

    asc_slot_state_t s_r;
    asc_slot_state_t s_nxt;

    assign fire = s_r.busy && (s_r.count == 6'h01);
    assign busy = s_r.busy;
    assign half_late = s_r.half;
    assign data = s_r.data;

    always_comb
    begin
        s_nxt = s_r;
        if (s_r.busy)
        begin
            s_nxt.count = s_r.count - 6'h01;
            if (fire)
            begin
                s_nxt.busy = 1'b0;
            end
        end
        // latency frozen per sample so later writes leave it alone
        if (load)
        begin
            s_nxt.busy = 1'b1;
            s_nxt.count = load_count;
            s_nxt.half = load_half;
            s_nxt.data = load_data;
        end
        if (clear)
        begin
            s_nxt = '0;
        end
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

endmodule

// ==== design/asc_setup_bank.sv ====
// setup register bank with per-sample latency pipeline behind an axi4-lite slave
//
// The address map and the AXI4-Lite slave port were left to the implementer.
module asc_setup_bank
    import asc_pkg::*;
#(
    parameter int SLOTS = 32
)
(
    // clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // register bus
    input wire asc_axil_req_t axil_req,
    output asc_axil_rsp_t axil_rsp,
    // sample path
    input wire logic video_sample_strobe,
    input wire logic [15:0] adc_sample_data,
    output asc_sample_t out_sample,
    // analogue control
    output asc_ctrl_t ctrl
);

    localparam int PTR_W = (SLOTS > 1) ? $clog2(SLOTS) : 1;

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        asc_wstate_t ws;
        logic got_aw;
        logic got_w;
        logic [ASC_ADDR_W-1:0] waddr;
        logic [ASC_DATA_W-1:0] wdata;
        logic [3:0] wstrb;
        asc_rstate_t rs;
        asc_axil_rsp_t rsp;
        logic [7:0] mode_ctrl;
        logic [7:0] out_ref;
        logic [7:0] dac_chan;
        logic strobe_meta;
        logic strobe_sync;
        logic strobe_prev;
        logic [PTR_W-1:0] wr_ptr;
        asc_sample_t out;
        asc_ctrl_t ctrl;
    } asc_state_t;

    asc_state_t s_r;
    asc_state_t s_nxt;

    // ----------------------------------------
    // slot wiring
    // ----------------------------------------
    logic soft_clear;
    logic strobe_edge;
    logic [SLOTS-1:0] slot_load;
    logic [SLOTS-1:0] slot_fire;
    logic [SLOTS-1:0] slot_busy;
    logic [SLOTS-1:0] slot_half;
    logic [15:0] slot_data [SLOTS];
    logic [6:0] lat_half;
    logic [1:0] cds_eff;
    logic [1:0] chan_eff;
    logic [2:0] power_eff;
    logic single_mode;
    logic compat_mode;
    logic [2:0] timing_mode;
    logic [1:0] lat_code;

    assign single_mode = s_r.mode_ctrl[ASC_MODE_SINGLE_BIT];
    assign compat_mode = s_r.mode_ctrl[ASC_MODE_COMPAT_BIT];
    assign timing_mode = s_r.mode_ctrl[ASC_MODE_TMODE_LSB +: 3];
    assign lat_code = s_r.out_ref[ASC_OUT_LAT_LSB +: 2];

    // only the second synchroniser stage feeds the edge detector
    assign strobe_edge = s_r.strobe_sync && !s_r.strobe_prev;

    // ----------------------------------------
    // derived settings
    // ----------------------------------------
    function automatic logic [6:0] lat_calc(input logic compat, input logic [2:0] tmode,
        input logic [1:0] code);
        logic [6:0] base;
        logic [6:0] step;
        base = ASC_LAT_NORM_BASE;
        step = ASC_LAT_NORM_STEP;
        if (compat && (tmode == ASC_TMODE_3))
        begin
            base = ASC_LAT_MODE3_BASE;
            step = ASC_LAT_MODE3_STEP;
        end
        else if (compat)
        begin
            base = ASC_LAT_COMPAT_BASE;
            step = ASC_LAT_COMPAT_STEP;
        end
        lat_calc = 7'(base + 7'(step * {5'h00, code}));
    endfunction

    always_comb
    begin
        lat_half = lat_calc(compat_mode, timing_mode, lat_code);
        cds_eff = ASC_CDSREF_DEFAULT;
        if (compat_mode)
        begin
            cds_eff = s_r.dac_chan[ASC_DAC_CDSREF_LSB +: 2];
        end
        chan_eff = ASC_CHAN_RED;
        power_eff = 3'h7;
        if (single_mode)
        begin
            chan_eff = s_r.dac_chan[ASC_DAC_CHAN_LSB +: 2];
            case (chan_eff)
                ASC_CHAN_RED: power_eff = 3'h1;
                ASC_CHAN_GREEN: power_eff = 3'h2;
                ASC_CHAN_BLUE: power_eff = 3'h4;
                // reserved code: keep every channel off rather than guess
                default: power_eff = 3'h0;
            endcase
        end
    end

    // ----------------------------------------
    // latency slots
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < SLOTS; gi++)
        begin : g_slot
            assign slot_load[gi] = strobe_edge && (s_r.wr_ptr == PTR_W'(gi));
            asc_lat_slot u_slot (
                .clock(clock),
                .arst_n(arst_n),
                .clear(soft_clear),
                .load(slot_load[gi]),
                .load_count(6'(lat_half[6:1] - 6'h01)),
                .load_half(lat_half[0]),
                .load_data(adc_sample_data),
                .fire(slot_fire[gi]),
                .busy(slot_busy[gi]),
                .half_late(slot_half[gi]),
                .data(slot_data[gi])
            );
        end
    endgenerate

    // ----------------------------------------
    // register read mux
    // ----------------------------------------
    function automatic logic [ASC_DATA_W-1:0] rd_mux(input asc_state_t s,
        input logic [ASC_ADDR_W-1:0] addr, input logic busy);
        rd_mux = '0;
        case (addr)
            ASC_OFS_MODE_CTRL: rd_mux = {24'h00_0000, s.mode_ctrl};
            ASC_OFS_OUT_REF: rd_mux = {24'h00_0000, s.out_ref};
            ASC_OFS_DAC_CHAN: rd_mux = {24'h00_0000, s.dac_chan};
            ASC_OFS_STATUS:
            begin
                rd_mux[ASC_STAT_LAT_LSB +: 7] = s.ctrl.latency_half;
                rd_mux[ASC_STAT_CHAN_LSB +: 2] = s.ctrl.chan_select;
                rd_mux[ASC_STAT_CDS_LSB +: 2] = s.ctrl.cds_reset_adjust;
                rd_mux[ASC_STAT_BUSY_BIT] = busy;
                rd_mux[ASC_STAT_SINGLE_BIT] = s.mode_ctrl[ASC_MODE_SINGLE_BIT];
                rd_mux[ASC_STAT_COMPAT_BIT] = s.mode_ctrl[ASC_MODE_COMPAT_BIT];
            end
            default: rd_mux = '0;
        endcase
    endfunction

    function automatic logic addr_ok(input logic [ASC_ADDR_W-1:0] addr, input logic wr);
        addr_ok = (addr == ASC_OFS_MODE_CTRL) || (addr == ASC_OFS_OUT_REF) ||
            (addr == ASC_OFS_DAC_CHAN) || (wr && (addr == ASC_OFS_SOFT_RST)) ||
            (!wr && (addr == ASC_OFS_STATUS));
    endfunction

    // soft reset fires on the cycle the write is committed; built from flops and inputs only
    assign soft_clear = (s_r.ws != ASC_WS_RESP) &&
        (s_r.got_aw || (axil_req.awvalid && s_r.rsp.awready)) &&
        (s_r.got_w || (axil_req.wvalid && s_r.rsp.wready)) &&
        ((s_r.got_aw ? s_r.waddr : axil_req.awaddr) == ASC_OFS_SOFT_RST);

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb
    begin
        s_nxt = s_r;

        // pin strobe through two flops first
        s_nxt.strobe_meta = video_sample_strobe;
        s_nxt.strobe_sync = s_r.strobe_meta;
        s_nxt.strobe_prev = s_r.strobe_sync;

        // write channel: address and data in either order
        if (axil_req.awvalid && s_r.rsp.awready)
        begin
            s_nxt.got_aw = 1'b1;
            s_nxt.waddr = axil_req.awaddr;
            s_nxt.rsp.awready = 1'b0;
        end
        if (axil_req.wvalid && s_r.rsp.wready)
        begin
            s_nxt.got_w = 1'b1;
            s_nxt.wdata = axil_req.wdata;
            s_nxt.wstrb = axil_req.wstrb;
            s_nxt.rsp.wready = 1'b0;
        end
        case (s_r.ws)
            ASC_WS_IDLE, ASC_WS_HALF:
            begin
                if (s_nxt.got_aw && s_nxt.got_w)
                begin
                    s_nxt.ws = ASC_WS_RESP;
                    s_nxt.rsp.bvalid = 1'b1;
                    s_nxt.rsp.bresp = addr_ok(s_nxt.waddr, 1'b1) ? ASC_RESP_OKAY : ASC_RESP_SLVERR;
                    // registers are byte wide: only lane zero carries them
                    if (s_nxt.wstrb[0])
                    begin
                        case (s_nxt.waddr)
                            ASC_OFS_MODE_CTRL: s_nxt.mode_ctrl = s_nxt.wdata[7:0];
                            ASC_OFS_OUT_REF: s_nxt.out_ref = s_nxt.wdata[7:0];
                            ASC_OFS_DAC_CHAN: s_nxt.dac_chan = s_nxt.wdata[7:0];
                            default: s_nxt.mode_ctrl = s_nxt.mode_ctrl;
                        endcase
                    end
                end
                else if (s_nxt.got_aw || s_nxt.got_w)
                begin
                    s_nxt.ws = ASC_WS_HALF;
                end
            end
            ASC_WS_RESP:
            begin
                if (axil_req.bready)
                begin
                    s_nxt.ws = ASC_WS_IDLE;
                    s_nxt.rsp.bvalid = 1'b0;
                    s_nxt.got_aw = 1'b0;
                    s_nxt.got_w = 1'b0;
                    s_nxt.rsp.awready = 1'b1;
                    s_nxt.rsp.wready = 1'b1;
                end
            end
            default:
            begin
                s_nxt.ws = ASC_WS_IDLE;
            end
        endcase

        // read channel
        case (s_r.rs)
            ASC_RS_IDLE:
            begin
                if (axil_req.arvalid)
                begin
                    s_nxt.rs = ASC_RS_RESP;
                    s_nxt.rsp.arready = 1'b0;
                    s_nxt.rsp.rvalid = 1'b1;
                    s_nxt.rsp.rdata = rd_mux(s_r, axil_req.araddr, |slot_busy);
                    s_nxt.rsp.rresp = addr_ok(axil_req.araddr, 1'b0) ? ASC_RESP_OKAY :
                        ASC_RESP_SLVERR;
                end
            end
            ASC_RS_RESP:
            begin
                if (axil_req.rready)
                begin
                    s_nxt.rs = ASC_RS_IDLE;
                    s_nxt.rsp.rvalid = 1'b0;
                    s_nxt.rsp.arready = 1'b1;
                end
            end
            default:
            begin
                s_nxt.rs = ASC_RS_IDLE;
            end
        endcase

        // settings that may follow the registers at once
        s_nxt.ctrl.dac_code = s_r.dac_chan[ASC_DAC_CODE_LSB +: 4];
        s_nxt.ctrl.dac_range = s_r.out_ref[ASC_OUT_DAC_RANGE_BIT];
        s_nxt.ctrl.chan_select = chan_eff;
        s_nxt.ctrl.chan_power = power_eff;
        s_nxt.ctrl.latency_half = lat_half;

        // reset sample shift is taken only at a new strobe
        if (strobe_edge)
        begin
            s_nxt.ctrl.cds_reset_adjust = cds_eff;
            s_nxt.wr_ptr = (s_r.wr_ptr == PTR_W'(SLOTS - 1)) ? '0 : PTR_W'(s_r.wr_ptr + 1'b1);
        end

        // output stage: lowest firing slot wins; collisions only if latency shrinks mid-flight
        s_nxt.out.valid = 1'b0;
        for (int i = SLOTS - 1; i >= 0; i--)
        begin
            if (slot_fire[i])
            begin
                s_nxt.out.valid = 1'b1;
                s_nxt.out.half_late = slot_half[i];
                s_nxt.out.data = slot_data[i];
            end
        end

        // soft reset: every setup cell and the pipeline back to reset, bus keeps answering
        if (soft_clear)
        begin
            s_nxt.mode_ctrl = ASC_MODE_CTRL_RST;
            s_nxt.out_ref = ASC_OUT_REF_RST;
            s_nxt.dac_chan = ASC_DAC_CHAN_RST;
            s_nxt.wr_ptr = '0;
            s_nxt.out = '0;
            s_nxt.ctrl.cds_reset_adjust = ASC_CDSREF_DEFAULT;
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_r <= '0;
            s_r.ws <= ASC_WS_IDLE;
            s_r.rs <= ASC_RS_IDLE;
            s_r.rsp.awready <= 1'b1;
            s_r.rsp.wready <= 1'b1;
            s_r.rsp.arready <= 1'b1;
            s_r.mode_ctrl <= ASC_MODE_CTRL_RST;
            s_r.out_ref <= ASC_OUT_REF_RST;
            s_r.dac_chan <= ASC_DAC_CHAN_RST;
            s_r.ctrl.dac_code <= ASC_DAC_CHAN_RST[3:0];
            s_r.ctrl.dac_range <= 1'b1;
            s_r.ctrl.chan_power <= 3'h7;
            s_r.ctrl.cds_reset_adjust <= ASC_CDSREF_DEFAULT;
            s_r.ctrl.latency_half <= ASC_LAT_NORM_BASE;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign axil_rsp = s_r.rsp;
    assign out_sample = s_r.out;
    assign ctrl = s_r.ctrl;

endmodule

// ==== testbench/asc_setup_bank_properties.sv ====
// checker: port-level properties of the setup register bank
module asc_setup_bank_properties
    import asc_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // watched ports
    input wire asc_axil_req_t axil_req,
    input wire asc_axil_rsp_t axil_rsp,
    input wire asc_sample_t out_sample,
    input wire asc_ctrl_t ctrl
);
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);

    property p_rst_vals;
        $rose(arst_n) |-> ctrl.dac_code == 4'hF && ctrl.dac_range && ctrl.chan_select == 2'h0;
    endproperty
    a_rst_vals: assert property (p_rst_vals) else $error("bad reset value");
    property p_lat_legal;
        ctrl.latency_half inside {7'h0E, 7'h10, 7'h12, 7'h14, 7'h21, 7'h25, 7'h29, 7'h2D,
            7'h2F, 7'h35, 7'h3B, 7'h41};
    endproperty
    a_lat_legal: assert property (p_lat_legal) else $error("bad latency");
    property p_power_sel;
        ctrl.chan_power != 3'h7 |->
            ctrl.chan_power == (ctrl.chan_select == 2'h3 ? 3'h0 : 3'h1 << ctrl.chan_select);
    endproperty
    a_power_sel: assert property (p_power_sel) else $error("bad channel power");
    property p_all_on;
        ctrl.chan_power == 3'h7 |-> ctrl.chan_select == 2'h0;
    endproperty
    a_all_on: assert property (p_all_on) else $error("select not ignored");
    property p_reserved;
        ctrl.chan_select == 2'h3 |-> ctrl.chan_power == 3'h0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved code powered");
    // adjust is frozen per strobe, so only a fresh capture must see compat latency
    property p_cds_compat;
        $changed(ctrl.cds_reset_adjust) && ctrl.cds_reset_adjust != ASC_CDSREF_DEFAULT
            |-> ctrl.latency_half >= 7'h21;
    endproperty
    a_cds_compat: assert property (p_cds_compat) else $error("adjust not ignored");
    property p_soft_rst;
        axil_req.awvalid && axil_rsp.awready && axil_req.wvalid && axil_rsp.wready
            && axil_req.awaddr == ASC_OFS_SOFT_RST |-> ##[1:3] ctrl.dac_code == 4'hF;
    endproperty
    a_soft_rst: assert property (p_soft_rst) else $error("soft reset missed");
    property p_soft_flush;
        axil_req.awvalid && axil_rsp.awready && axil_req.wvalid && axil_rsp.wready
            && axil_req.awaddr == ASC_OFS_SOFT_RST |=> !out_sample.valid;
    endproperty
    a_soft_flush: assert property (p_soft_flush) else $error("pipeline not flushed");
    property p_dac_write;
        $changed(ctrl.dac_code) |->
            $past(axil_rsp.bvalid) || $past(axil_rsp.bvalid, 2) || $past(axil_rsp.bvalid, 3);
    endproperty
    a_dac_write: assert property (p_dac_write) else $error("code moved unasked");
endmodule

bind asc_setup_bank asc_setup_bank_properties u_props (
    .clock(clock),
    .arst_n(arst_n),
    .axil_req(axil_req),
    .axil_rsp(axil_rsp),
    .out_sample(out_sample),
    .ctrl(ctrl)
);

// ==== testbench/asc_setup_bank_bench.sv ====
// bench: self-checking test of the setup register bank
module asc_setup_bank_bench
    import asc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // --------
    // signals and model
    // --------
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    asc_axil_req_t req = '0;
    asc_axil_rsp_t rsp;
    logic strobe = 1'b0;
    logic [15:0] adc = 16'h0000;
    asc_sample_t smp;
    asc_ctrl_t ctrl;
    int n_mismatch = 0;
    int total_checks = 0;
    int cycles = 0;
    int m_mode = ASC_MODE_CTRL_RST;
    int m_out = ASC_OUT_REF_RST;
    int m_dac = ASC_DAC_CHAN_RST;

    asc_setup_bank dut (
        .clock(clock),
        .arst_n(arst_n),
        .axil_req(req),
        .axil_rsp(rsp),
        .video_sample_strobe(strobe),
        .adc_sample_data(adc),
        .out_sample(smp),
        .ctrl(ctrl)
    );

    initial
        forever #12.5 clock = ~clock;

    // hang guard, far above the several hundred cycles needed
    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            n_mismatch++;
            results();
        end
    end
    // --------
    // tasks
    // --------
    task automatic results();
        $display("mismatches %0d checks %0d", n_mismatch, total_checks);
        if (n_mismatch == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic mw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= d;
        req.wstrb <= s;
        req.bready <= 1'b1;
        do
        begin
            @(posedge clock);
            if (req.awvalid && rsp.awready)
                req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready)
                req.wvalid <= 1'b0;
        end while (!rsp.bvalid);
        chk(32'(rsp.bresp), a inside {8'h00, 8'h08, 8'h0C, 8'h10} ? 32'h0 : 32'h2);
        req.bready <= 1'b0;
        @(posedge clock);
        if (a == ASC_OFS_SOFT_RST)
        begin
            m_mode = ASC_MODE_CTRL_RST;
            m_out = ASC_OUT_REF_RST;
            m_dac = ASC_DAC_CHAN_RST;
        end
        else if (s[0] && a == ASC_OFS_MODE_CTRL)
            m_mode = d[7:0];
        else if (s[0] && a == ASC_OFS_OUT_REF)
            m_out = d[7:0];
        else if (s[0] && a == ASC_OFS_DAC_CHAN)
            m_dac = d[7:0];
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= 1'b1;
        do
        begin
            @(posedge clock);
            if (rsp.arready)
                req.arvalid <= 1'b0;
        end while (!rsp.rvalid);
        chk(rsp.rdata, e);
        chk(32'(rsp.rresp), 32'(er));
        req.rready <= 1'b0;
        @(posedge clock);
    endtask

    function automatic int lat_exp();
        if (!m_mode[1])
            return 14 + 2 * m_out[7:6];
        return m_mode[4:2] == 3 ? 47 + 6 * m_out[7:6] : 33 + 4 * m_out[7:6];
    endfunction

    // one strobe; the count runs from the edge that samples the pin high
    task automatic pulse();
        int n;
        int lat;
        logic [15:0] d;
        lat = lat_exp();
        chk(32'(ctrl.latency_half), lat);
        d = 16'($urandom());
        n = 0;
        strobe <= 1'b1;
        adc <= d;
        @(posedge clock);
        do
        begin
            @(posedge clock);
            n++;
            if (n == 3)
                strobe <= 1'b0;
        end while (!smp.valid && n < 200);
        chk(n, 2 + lat / 2);
        chk(32'(smp.half_late), lat % 2);
        chk(32'(smp.data), 32'(d));
    endtask

    task automatic rchk();
        rd_chk(ASC_OFS_MODE_CTRL, m_mode, ASC_RESP_OKAY);
        rd_chk(ASC_OFS_OUT_REF, m_out, ASC_RESP_OKAY);
        rd_chk(ASC_OFS_DAC_CHAN, m_dac, ASC_RESP_OKAY);
    endtask

    task automatic cchk();
        chk(32'(ctrl.dac_code), m_dac[3:0]);
        chk(32'(ctrl.dac_range), m_out[5]);
        chk(32'(ctrl.chan_select), m_mode[0] ? m_dac[7:6] : 0);
        chk(32'(ctrl.chan_power), !m_mode[0] ? 7 : m_dac[7:6] == 3 ? 0 : 1 << m_dac[7:6]);
        chk(32'(ctrl.cds_reset_adjust), m_mode[1] ? m_dac[5:4] : 1);
    endtask
    // --------
    // main sequence
    // --------
    initial
    begin
        void'($urandom(87));
        repeat (12) @(posedge clock);
        arst_n <= 1'b1;
        @(posedge clock);
        rchk();
        rd_chk(ASC_OFS_STATUS, 32'h0000_020E, ASC_RESP_OKAY);
        rd_chk(8'h04, 32'h0000_0000, ASC_RESP_SLVERR);
        rd_chk(ASC_OFS_SOFT_RST, 32'h0000_0000, ASC_RESP_SLVERR);
        cchk();
        mw(ASC_OFS_SOFT_RST, 32'h0, 4'h1);
        $display("test reset done");
        for (int cfg = 0; cfg < 3; cfg++)
            for (int dl = 0; dl < 4; dl++)
            begin
                mw(ASC_OFS_MODE_CTRL, cfg == 0 ? 32'h04 : cfg == 1 ? 32'h06 : 32'h0E, 4'h1);
                mw(ASC_OFS_OUT_REF, dl << 6 | $urandom % 64, 4'h1);
                pulse();
            end
        // latency shortened while a sample is in flight: that sample keeps its own
        fork
            pulse();
            begin
                repeat (4) @(posedge clock);
                mw(ASC_OFS_OUT_REF, 32'h20, 4'h1);
            end
        join
        pulse();
        $display("test latency done");
        mw(ASC_OFS_MODE_CTRL, 32'h07, 4'h1);
        for (int i = 0; i < 16; i++)
        begin
            mw(ASC_OFS_DAC_CHAN, i << 4 | $urandom % 16, 4'h1);
            pulse();
            cchk();
        end
        // both modes off: channel and adjust fields must be ignored
        mw(ASC_OFS_MODE_CTRL, 32'h04, 4'h1);
        mw(ASC_OFS_DAC_CHAN, 32'hA3, 4'h1);
        pulse();
        cchk();
        mw(ASC_OFS_DAC_CHAN, 32'h55, 4'h0);
        mw(8'h18, 32'hFF, 4'hF);
        rchk();
        $display("test channel done");
        mw(ASC_OFS_MODE_CTRL, 32'h0F, 4'h1);
        mw(ASC_OFS_OUT_REF, 32'hC5, 4'h1);
        mw(ASC_OFS_SOFT_RST, $urandom, 4'($urandom));
        rchk();
        pulse();
        cchk();
        $display("test soft reset done");
        results();
    end
endmodule
